/* mqf_top.sv */
// mqf_top: multi-queue fifo core with apb configuration and flag buses
// assumes host logic drives both ports on pclk; one device id per part
`timescale 1ns/1ps
module mqf_top #(
  parameter int         BLOCKS = mqf_pkg::POOL_BLOCKS,
  parameter logic [2:0] DEV_ID = 3'h0
) (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [mqf_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // strap
  input  wire logic                        default_offset_select,
  // write port
  input  wire mqf_pkg::mqf_wr_t            wr,
  output logic                             write_full_flag,
  output logic                             almost_full_flag,
  // read port
  input  wire mqf_pkg::mqf_rd_t            rd,
  output logic      [mqf_pkg::DW-1:0]      rd_data,
  output logic                             read_valid_flag,
  output logic                             almost_empty_flag,
  output logic                             packet_ready,
  // flag status buses
  input  wire mqf_pkg::mqf_fsel_t          af_sel,
  input  wire mqf_pkg::mqf_fsel_t          ae_sel,
  output logic      [mqf_pkg::SW-1:0]      af_bus,
  output logic      [mqf_pkg::SWS_W-1:0]   af_word,
  output logic      [mqf_pkg::SW-1:0]      ae_bus,
  output logic      [mqf_pkg::SWS_W-1:0]   ae_word
);
  import mqf_pkg::*;

  localparam int AW = $clog2(BLOCKS) + BLK_SH;

  ////////////////////////////////////////////////////////////////////////////
  // state and helpers

  typedef struct packed {
    mqf_ctrl_t                    ctrl;
    logic [QW-1:0]                qsel;
    mqf_alloc_t [NQ-1:0]          alloc;
    mqf_offs_t  [NQ-1:0]          offs;
    logic [NQ-1:0][PTR_W-1:0]     wptr;
    logic [NQ-1:0][PTR_W-1:0]     rptr;
    logic [NQ-1:0][CNT_W-1:0]     cnt;
    logic [NQ-1:0][CNT_W-1:0]     pkt;
    logic                         init_done;
    logic [QA_W-1:0]              rq_prev;
    logic [2:0]                   dly;
    logic                         wfull;
    logic                         waf;
    logic                         rvalid;
    logic                         rae;
    logic                         prdy;
    logic [DW-1:0]                rd_data;
    logic                         pready;
    logic                         pslverr;
    logic [31:0]                  prdata;
  } mqf_st_t;

  mqf_st_t r;
  mqf_st_t n;

  function automatic logic [CNT_W-1:0] qcap(mqf_alloc_t a);
    return {a.size, BLK_LO};
  endfunction

  function automatic logic [PTR_W-1:0] ptr_inc(logic [PTR_W-1:0] p, mqf_alloc_t a);
    logic [CNT_W-1:0] nx;
    nx = {1'b0, p} + CNT_W'(1);
    return (nx >= qcap(a)) ? '0 : nx[PTR_W-1:0];
  endfunction

  function automatic logic [AW-1:0] maddr(mqf_alloc_t a, logic [PTR_W-1:0] p);
    logic [CNT_W:0] s;
    s = {1'b0, a.base, BLK_LO} + (CNT_W+1)'(p);
    return s[AW-1:0];
  endfunction

  function automatic logic [DW-1:0] wmask(logic [1:0] w);
    return (w == W9) ? MASK9 : (w == W18) ? MASK18 : MASK36;
  endfunction

  function automatic logic reg_known(logic [PADDR_W-1:0] a);
    return a == REG_CTRL || a == REG_QSEL || a == REG_ALLOC || a == REG_OFFS || a == REG_STAT;
  endfunction

  function automatic logic af_hit(logic [CNT_W-1:0] c, mqf_alloc_t a, mqf_offs_t o);
    return ({1'b0, c} + (CNT_W+1)'(o.af)) >= {1'b0, qcap(a)};
  endfunction

  function automatic logic ae_hit(logic [CNT_W-1:0] c, mqf_offs_t o);
    return c <= CNT_W'(o.ae);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // port decode

  logic              exp_on;
  logic [QW-1:0]     wq;
  logic [QW-1:0]     rq;
  logic              wsel_ok;
  logic              rsel_ok;
  logic              full_w;
  logic              do_wr;
  logic              rq_chg;
  logic              gate;
  logic              do_rd;
  logic [AW-1:0]     waddr;
  logic [AW-1:0]     raddr;
  logic [DW-1:0]     wdata;
  logic [DW-1:0]     mem_q;
  logic [DW-1:0]     rd_word;
  logic              pop_eop;
  logic              setup;
  logic              cfg_wr;
  logic [NQ-1:0]     af_vec;
  logic [NQ-1:0]     ae_vec;
  logic [OFF_W-1:0]  dflt_off;

  // expansion decode would break fall-through latency, so it is gated off
  assign exp_on  = r.ctrl.expand_en && !r.ctrl.fall_through_mode;
  assign wq      = wr.queue[QW-1:0];
  assign rq      = rd.queue[QW-1:0];
  assign wsel_ok = (wq <= r.ctrl.nq_m1) && (!exp_on || wr.queue[QA_W-1:QW] == DEV_ID);
  assign rsel_ok = (rq <= r.ctrl.nq_m1) && (!exp_on || rd.queue[QA_W-1:QW] == DEV_ID);
  assign full_w  = r.cnt[wq] >= qcap(r.alloc[wq]);
  assign do_wr   = wr.en && wsel_ok && !full_w;
  assign waddr   = maddr(r.alloc[wq], r.wptr[wq]);
  assign wdata   = wr.data & wmask(r.ctrl.wr_width);
  assign rq_chg  = rd.queue != r.rq_prev;
  assign gate    = rsel_ok && !rq_chg && r.dly == '0;
  assign do_rd   = gate && r.cnt[rq] != '0 && rd.en && (!r.ctrl.fall_through_mode || r.rvalid);
  // fall-through shows the head, so a pop reads the word behind it
  assign raddr   = (r.ctrl.fall_through_mode && do_rd) ? maddr(r.alloc[rq], ptr_inc(r.rptr[rq], r.alloc[rq]))
                                                       : maddr(r.alloc[rq], r.rptr[rq]);
  // same-cycle write to the word being fetched must bypass the array
  assign rd_word = (do_wr && waddr == raddr) ? wdata : mem_q;
  assign pop_eop = r.ctrl.fall_through_mode ? r.rd_data[EOP_BIT] : rd_word[EOP_BIT];
  assign setup   = psel && !penable;
  assign cfg_wr  = psel && penable && r.pready && pwrite;
  assign dflt_off = default_offset_select ? OFF_HI : OFF_LO;

  mqf_ram #(
    .AW (AW),
    .DW (DW)
  ) u_ram (
    .pclk  (pclk),
    .we    (do_wr),
    .waddr (waddr),
    .wdata (wdata),
    .raddr (raddr),
    .rdata (mem_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = r;
    // strap is read on the first edge after release, never by the reset
    if (!r.init_done) begin
      n.init_done = 1'b1;
      for (int q = 0; q < NQ; q++) begin
        n.offs[q] = '{af: dflt_off, ae: dflt_off};
      end
    end

    // queue data path
    if (do_wr) begin
      n.wptr[wq] = ptr_inc(r.wptr[wq], r.alloc[wq]);
    end
    if (do_rd) begin
      n.rptr[rq] = ptr_inc(r.rptr[rq], r.alloc[rq]);
    end
    for (int q = 0; q < NQ; q++) begin
      n.cnt[q] = r.cnt[q] + CNT_W'(do_wr && wq == QW'(q)) - CNT_W'(do_rd && rq == QW'(q));
      n.pkt[q] = r.pkt[q]
               + CNT_W'(r.ctrl.packet_mode && do_wr && wq == QW'(q) && wdata[EOP_BIT])
               - CNT_W'(r.ctrl.packet_mode && do_rd && rq == QW'(q) && pop_eop);
    end

    // apb
    n.pready  = setup;
    n.pslverr = setup && !reg_known(paddr);
    n.prdata  = '0;
    if (setup) begin
      unique case (paddr)
        REG_CTRL:  n.prdata = 32'(r.ctrl);
        REG_QSEL:  n.prdata = 32'(r.qsel);
        REG_ALLOC: n.prdata = 32'(r.alloc[r.qsel]);
        REG_OFFS:  n.prdata = 32'(r.offs[r.qsel]);
        REG_STAT:  n.prdata = 32'(mqf_stat_t'{pkt:   r.pkt[r.qsel] != '0,
                                             full:  r.cnt[r.qsel] >= qcap(r.alloc[r.qsel]),
                                             empty: r.cnt[r.qsel] == '0,
                                             level: r.cnt[r.qsel]});
        default:   n.prdata = '0;
      endcase
    end
    if (cfg_wr) begin
      unique case (paddr)
        REG_CTRL:  n.ctrl = mqf_ctrl_t'(pwdata[$bits(mqf_ctrl_t)-1:0]);
        REG_QSEL:  n.qsel = pwdata[QW-1:0];
        REG_ALLOC: begin
          // resizing a queue discards its contents
          n.alloc[r.qsel] = mqf_alloc_t'(pwdata[$bits(mqf_alloc_t)-1:0]);
          n.wptr[r.qsel]  = '0;
          n.rptr[r.qsel]  = '0;
          n.cnt[r.qsel]   = '0;
          n.pkt[r.qsel]   = '0;
        end
        REG_OFFS:  n.offs[r.qsel] = mqf_offs_t'(pwdata);
        default:   n.ctrl = r.ctrl;
      endcase
    end

    // read output stage
    n.rq_prev = rd.queue;
    if (rq_chg) begin
      n.dly = (r.ctrl.fall_through_mode ? DLY_FALL_THROUGH_MODE : DLY_STD) - 3'h1;
    end else if (r.dly != '0) begin
      n.dly = r.dly - 3'h1;
    end
    if (r.ctrl.fall_through_mode) begin
      if (!gate) begin
        n.rvalid = 1'b0;
      end else if (r.rvalid && !do_rd) begin
        n.rvalid = 1'b1;
      end else if (n.cnt[rq] != '0) begin
        n.rd_data = rd_word & wmask(r.ctrl.rd_width);
        n.rvalid  = 1'b1;
      end else begin
        n.rvalid = 1'b0;
      end
    end else begin
      if (do_rd) begin
        n.rd_data = rd_word & wmask(r.ctrl.rd_width);
      end
      n.rvalid = gate && n.cnt[rq] != '0;
    end

    // dedicated flags follow the selected queues
    n.wfull = !wsel_ok || n.cnt[wq] >= qcap(n.alloc[wq]);
    n.waf   = !wsel_ok || af_hit(n.cnt[wq], n.alloc[wq], n.offs[wq]);
    n.rae   = !gate || ae_hit(n.cnt[rq], n.offs[rq]);
    n.prdy  = gate && n.pkt[rq] != '0 && n.rvalid;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag status buses

  always_comb begin
    for (int q = 0; q < NQ; q++) begin
      af_vec[q] = (QW'(q) <= r.ctrl.nq_m1) && af_hit(r.cnt[q], r.alloc[q], r.offs[q]);
      ae_vec[q] = (QW'(q) <= r.ctrl.nq_m1) &&
                  (r.ctrl.packet_mode ? r.pkt[q] != '0 : ae_hit(r.cnt[q], r.offs[q]));
    end
  end

  mqf_flag_bus u_af_bus (
    .pclk        (pclk),
    .presetn     (presetn),
    .direct_mode (r.ctrl.direct_mode),
    .sel         (af_sel),
    .flags       (af_vec),
    .bus         (af_bus),
    .word        (af_word)
  );

  mqf_flag_bus u_ae_bus (
    .pclk        (pclk),
    .presetn     (presetn),
    .direct_mode (r.ctrl.direct_mode),
    .sel         (ae_sel),
    .flags       (ae_vec),
    .bus         (ae_bus),
    .word        (ae_word)
  );

  assign prdata            = r.prdata;
  assign pready            = r.pready;
  assign pslverr           = r.pslverr;
  assign write_full_flag   = r.wfull;
  assign almost_full_flag  = r.waf;
  assign rd_data           = r.rd_data;
  assign read_valid_flag   = r.rvalid;
  assign almost_empty_flag = r.rae;
  assign packet_ready      = r.prdy;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_apb_ready;
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb answer not one cycle");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    (setup && !reg_known(paddr)) |=> pslverr && prdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

  property p_full_block;
    @(posedge pclk) disable iff (!presetn)
    (wr.en && full_w && !do_rd && !cfg_wr && r.init_done) |=> $stable(r.cnt);
  endproperty
  a_full_block: assert property (p_full_block) else $error("write into full queue");

  property p_std_delay;
    @(posedge pclk) disable iff (!presetn)
    (rq_chg && !r.ctrl.fall_through_mode && !cfg_wr) |=> !read_valid_flag [*3];
  endproperty
  a_std_delay: assert property (p_std_delay) else $error("standard flag settled early");

  property p_fall_through_mode_delay;
    @(posedge pclk) disable iff (!presetn)
    (rq_chg && r.ctrl.fall_through_mode && !cfg_wr) |=> !read_valid_flag [*4];
  endproperty
  a_fall_through_mode_delay: assert property (p_fall_through_mode_delay) else $error("fall-through flag settled early");

  property p_fall_through_mode_hold;
    @(posedge pclk) disable iff (!presetn)
    (r.ctrl.fall_through_mode && !read_valid_flag) ##1 !read_valid_flag |-> $stable(rd_data);
  endproperty
  a_fall_through_mode_hold: assert property (p_fall_through_mode_hold) else $error("output changed while not valid");

  property p_pkt_qual;
    @(posedge pclk) disable iff (!presetn)
    packet_ready |-> read_valid_flag && r.pkt[r.rq_prev[QW-1:0]] != '0;
  endproperty
  a_pkt_qual: assert property (p_pkt_qual) else $error("packet ready without packet");

  property p_rd_mask;
    @(posedge pclk) disable iff (!presetn)
    (do_rd && r.ctrl.rd_width == W9 && !r.ctrl.fall_through_mode) |=> (rd_data & ~MASK9) == '0;
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("x9 read leaks upper bits");
endmodule

/* mqf_pkg.sv */
// mqf_pkg: constants, carriers and register map of the multi-queue fifo
// assumes a single pclk domain and an apb slave port for configuration
package mqf_pkg;
  localparam int NQ          = 32;
  localparam int QW          = 5;
  localparam int QA_W        = 8;
  localparam int DW          = 36;
  localparam int SOP_BIT     = 34;
  localparam int EOP_BIT     = 35;
  localparam int BLK_SH      = 8;
  localparam int BLK_W       = 10;
  localparam int PTR_W       = 17;
  localparam int CNT_W       = 18;
  localparam int OFF_W       = 16;
  localparam int SW          = 8;
  localparam int SWS_W       = 2;
  localparam int POOL_BLOCKS = 128;
  localparam int PADDR_W     = 12;
  localparam logic [2:0]          DLY_STD  = 3'h3;
  localparam logic [2:0]          DLY_FALL_THROUGH_MODE = 3'h4;
  localparam logic [OFF_W-1:0]    OFF_LO   = 16'h0008;
  localparam logic [OFF_W-1:0]    OFF_HI   = 16'h0080;
  localparam logic [BLK_SH-1:0]   BLK_LO   = 8'h00;
  localparam logic [1:0]          W9       = 2'h0;
  localparam logic [1:0]          W18      = 2'h1;
  localparam logic [DW-1:0]       MASK9    = 36'h0000001FF;
  localparam logic [DW-1:0]       MASK18   = 36'h00003FFFF;
  localparam logic [DW-1:0]       MASK36   = 36'hFFFFFFFFF;
  localparam logic [PADDR_W-1:0]  REG_CTRL  = 12'h000;
  localparam logic [PADDR_W-1:0]  REG_QSEL  = 12'h004;
  localparam logic [PADDR_W-1:0]  REG_ALLOC = 12'h008;
  localparam logic [PADDR_W-1:0]  REG_OFFS  = 12'h00C;
  localparam logic [PADDR_W-1:0]  REG_STAT  = 12'h010;

  typedef struct packed {
    logic [QW-1:0] nq_m1;
    logic [1:0]    rd_width;
    logic [1:0]    wr_width;
    logic          expand_en;
    logic          direct_mode;
    logic          packet_mode;
    logic          fall_through_mode;
  } mqf_ctrl_t;

  typedef struct packed {
    logic [BLK_W-1:0] size;
    logic [BLK_W-1:0] base;
  } mqf_alloc_t;

  typedef struct packed {
    logic [OFF_W-1:0] af;
    logic [OFF_W-1:0] ae;
  } mqf_offs_t;

  typedef struct packed {
    logic             pkt;
    logic             full;
    logic             empty;
    logic [CNT_W-1:0] level;
  } mqf_stat_t;

  typedef struct packed {
    logic            en;
    logic [QA_W-1:0] queue;
    logic [DW-1:0]   data;
  } mqf_wr_t;

  typedef struct packed {
    logic            en;
    logic [QA_W-1:0] queue;
  } mqf_rd_t;

  typedef struct packed {
    logic             strobe;
    logic [SWS_W-1:0] word;
  } mqf_fsel_t;
endpackage

/* mqf_ram.sv */
// mqf_ram: shared queue storage, one write port and one read port
// assumes addresses already carry block base plus queue pointer
`timescale 1ns/1ps
module mqf_ram #(
  parameter int AW = 15,
  parameter int DW = 36
) (
  // clock
  input  wire logic          pclk,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read side, combinational so fall-through needs no extra stage
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [(1<<AW)];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule

/* mqf_flag_bus.sv */
// mqf_flag_bus: one eight-bit flag status bus, polled or direct
// assumes per-queue flags arrive registered from the queue core
`timescale 1ns/1ps
module mqf_flag_bus (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // selection
  input  wire logic                      direct_mode,
  input  wire mqf_pkg::mqf_fsel_t        sel,
  input  wire logic [mqf_pkg::NQ-1:0]    flags,
  // bus
  output logic      [mqf_pkg::SW-1:0]    bus,
  output logic      [mqf_pkg::SWS_W-1:0] word
);
  import mqf_pkg::*;

  typedef struct packed {
    logic [SW-1:0]    bus;
    logic [SWS_W-1:0] word;
  } mqf_fb_st_t;

  mqf_fb_st_t r;
  mqf_fb_st_t n;

  always_comb begin
    n = r;
    if (direct_mode) begin
      if (sel.strobe) begin
        n.word = sel.word;
      end
    end else begin
      // two-bit index wraps so all four words show even if unused
      n.word = r.word + SWS_W'(1);
    end
    n.bus = flags[n.word*SW +: SW];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bus  = r.bus;
  assign word = r.word;

  property p_poll_step;
    @(posedge pclk) disable iff (!presetn)
    !direct_mode |=> word == SWS_W'($past(word) + SWS_W'(1));
  endproperty
  a_poll_step: assert property (p_poll_step) else $error("polled word did not advance");

  property p_direct_load;
    @(posedge pclk) disable iff (!presetn)
    (direct_mode && sel.strobe) |=> (word == $past(sel.word)) && (bus == $past(flags[sel.word*SW +: SW]));
  endproperty
  a_direct_load: assert property (p_direct_load) else $error("direct word not selected");
endmodule

/* mqf_host.sv */
// mqf_host: host logic driving the write, read and flag-select ports
// assumes one pclk; the bench calls its tasks hierarchically
`timescale 1ns/1ps
module mqf_host (
  // clock
  input  wire logic          pclk,
  // driven ports
  output mqf_pkg::mqf_wr_t   wr,
  output mqf_pkg::mqf_rd_t   rd,
  output mqf_pkg::mqf_fsel_t af_sel,
  output mqf_pkg::mqf_fsel_t ae_sel
);
  import mqf_pkg::*;
  initial begin
    wr = '0;
    rd = '0;
    af_sel = '0;
    ae_sel = '0;
  end
  ////////////////////////////////////////////////////////////
  // back-to-back calls keep en high, one word per edge
  task automatic put(input logic [QA_W-1:0] q, input logic [DW-1:0] d);
    @(posedge pclk);
    wr <= '{en: 1'b1, queue: q, data: d};
  endtask
  // idle still steers the full flag to a queue
  task automatic idle(input logic [QA_W-1:0] q);
    @(posedge pclk);
    wr <= '{en: 1'b0, queue: q, data: '0};
  endtask
  task automatic sel_rd(input logic [QA_W-1:0] q);
    @(posedge pclk);
    rd.queue <= q;
  endtask
  task automatic pop();
    @(posedge pclk);
    rd.en <= 1'b1;
    @(posedge pclk);
    rd.en <= 1'b0;
  endtask
  // status word choice per bus, independent
  task automatic fsel(input logic [SWS_W-1:0] a, input logic [SWS_W-1:0] e);
    @(posedge pclk);
    af_sel <= '{strobe: 1'b1, word: a};
    ae_sel <= '{strobe: 1'b1, word: e};
    @(posedge pclk);
    af_sel.strobe <= 1'b0;
    ae_sel.strobe <= 1'b0;
  endtask
endmodule

/* multi_queue_flow_fifo_test.sv */
// multi_queue_flow_fifo_test: apb setup, queue traffic and flag buses
// assumes mqf_top register map and port contract as handed over
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module multi_queue_flow_fifo_test;
  import mqf_pkg::*;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [PADDR_W-1:0]  paddr = '0;
  logic [31:0]         pwdata = '0;
  logic                default_offset_select = 1'b0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  mqf_wr_t             wr;
  mqf_rd_t             rd;
  mqf_fsel_t           af_sel;
  mqf_fsel_t           ae_sel;
  logic [DW-1:0]       rd_data;
  logic                write_full_flag;
  logic                almost_full_flag;
  logic                read_valid_flag;
  logic                almost_empty_flag;
  logic                packet_ready;
  logic [SW-1:0]       af_bus;
  logic [SW-1:0]       ae_bus;
  logic [SWS_W-1:0]    af_word;
  logic [SWS_W-1:0]    ae_word;
  logic [SWS_W-1:0]    w;
  logic [31:0]         rdat;
  logic                rerr;
  logic [DW-1:0]       exp_q0 [3];
  int                  fail_count = 0;
  int                  tests_run = 0;
  int                  cycles = 0;
  always #4 pclk = ~pclk;
  ////////////////////////////////////////////////////////////
  mqf_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .default_offset_select(default_offset_select), .wr(wr),
    .write_full_flag(write_full_flag), .almost_full_flag(almost_full_flag), .rd(rd),
    .rd_data(rd_data), .read_valid_flag(read_valid_flag), .almost_empty_flag(almost_empty_flag),
    .packet_ready(packet_ready), .af_sel(af_sel), .ae_sel(ae_sel), .af_bus(af_bus),
    .af_word(af_word), .ae_bus(ae_bus), .ae_word(ae_word));
  mqf_host i_host (.pclk(pclk), .wr(wr), .rd(rd), .af_sel(af_sel), .ae_sel(ae_sel));
  ////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // request held until pready is seen at a rising edge
  // no wait limit here: only the bench timeout ends a hung access
  task automatic apb(input logic is_wr, input logic [PADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= is_wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // settle window after a read-queue change, in cycles
  task automatic settle(input int last);
    @(posedge pclk);
    for (int j = 0; j <= last; j++) begin
      @(negedge pclk);
      `CHK("settle_valid", (j == last), read_valid_flag)
    end
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    exp_q0 = '{36'h400000011, 36'h000000022, 36'h800000033};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, REG_CTRL, 32'h0);
    `CHK("ctrl_reset", 32'h0, rdat)
    apb(1'b0, REG_OFFS, 32'h0);
    `CHK("offs_dflt", 32'h00080008, rdat)
    apb(1'b1, REG_CTRL, 32'h000001A2);
    for (int q = 0; q < 2; q++) begin
      apb(1'b1, REG_QSEL, 32'(q));
      apb(1'b1, REG_ALLOC, 32'h00000400 | 32'(q));
    end
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped_err", 1'b1, rerr)
    `CHK("unmapped_data", 32'h0, rdat)
    // packet traffic on queue 0, end marker held back
    i_host.sel_rd(8'h00);
    i_host.put(8'h00, exp_q0[0]);
    i_host.put(8'h00, exp_q0[1]);
    i_host.idle(8'h00);
    repeat (6) @(negedge pclk);
    `CHK("pkt_partial", 1'b0, packet_ready)
    `CHK("valid_q0", 1'b1, read_valid_flag)
    `CHK("ae_q0", 1'b1, almost_empty_flag)
    i_host.put(8'h00, exp_q0[2]);
    i_host.idle(8'h00);
    repeat (3) @(negedge pclk);
    `CHK("pkt_ready", 1'b1, packet_ready)
    repeat (4) begin
      @(negedge pclk);
      if (ae_word === 2'h0) break;
    end
    `CHK("ae_bus_pkt", 1'b1, ae_bus[0])
    for (int i = 0; i < 5; i++) begin
      w = af_word;
      @(negedge pclk);
      `CHK("af_poll_step", 2'(w + 2'h1), af_word)
      `CHK("ae_poll_word", af_word, ae_word)
    end
    // fill one block of queue 1, then one word too many
    for (int i = 0; i < 256; i++) i_host.put(8'h01, 36'(i));
    i_host.put(8'h01, 36'h000000ABC);
    i_host.idle(8'h01);
    repeat (2) @(negedge pclk);
    `CHK("full_q1", 1'b1, write_full_flag)
    `CHK("af_q1", 1'b1, almost_full_flag)
    apb(1'b1, REG_QSEL, 32'h1);
    apb(1'b0, REG_STAT, 32'h0);
    `CHK("level_q1", 18'h00100, rdat[17:0])
    i_host.idle(8'h00);
    repeat (2) @(negedge pclk);
    `CHK("full_q0", 1'b0, write_full_flag)
    `CHK("af_q0", 1'b0, almost_full_flag)
    // standard-mode reads drain queue 0
    for (int i = 0; i < 3; i++) begin
      i_host.pop();
      @(negedge pclk);
      `CHK("rd_q0", exp_q0[i], rd_data)
    end
    i_host.pop();
    repeat (2) @(negedge pclk);
    `CHK("empty_q0", 1'b0, read_valid_flag)
    `CHK("hold_q0", exp_q0[2], rd_data)
    i_host.sel_rd(8'h01);
    settle(3);
    i_host.pop();
    @(negedge pclk);
    `CHK("rd_q1", 36'h000000000, rd_data)
    // direct mode: words stay where the host put them
    apb(1'b1, REG_CTRL, 32'h000001A6);
    i_host.fsel(2'h0, 2'h1);
    repeat (3) @(negedge pclk);
    `CHK("af_direct", 2'h0, af_word)
    `CHK("ae_direct", 2'h1, ae_word)
    `CHK("af_bus_q1", 1'b1, af_bus[1])
    // fall-through: empty queue keeps last word, head falls through
    apb(1'b1, REG_CTRL, 32'h000001A1);
    i_host.sel_rd(8'h00);
    repeat (6) @(negedge pclk);
    `CHK("hold_switch", 36'h000000000, rd_data)
    i_host.sel_rd(8'h01);
    settle(4);
    `CHK("ft_head", 36'h000000001, rd_data)
    // expansion in standard mode, read port narrowed to x9
    apb(1'b1, REG_CTRL, 32'h0000012A);
    i_host.idle(8'h20);
    repeat (2) @(negedge pclk);
    `CHK("exp_other_dev", 1'b1, write_full_flag)
    i_host.put(8'h00, 36'hFFFFFFFAB);
    i_host.idle(8'h00);
    i_host.sel_rd(8'h00);
    settle(3);
    i_host.pop();
    @(negedge pclk);
    `CHK("rd_x9", 36'h0000001AB, rd_data)
    // second reset with the strap high
    @(posedge pclk);
    presetn               <= 1'b0;
    default_offset_select <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, REG_OFFS, 32'h0);
    `CHK("offs_strap", 32'h00800080, rdat)
    wrap_up();
  end
endmodule
